/* File: core/car_defines.svh */
/*
 * Constants of the cache attribute resolver: register offsets, field
 * positions of a control entry, reset values and field codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CAR_DEFINES_SVH
`define CAR_DEFINES_SVH

`define CAR_ENTRY_COUNT     32
`define CAR_ENTRY_W         13
`define CAR_OFF_ENTRY0      12'h000
`define CAR_OFF_ICR         12'h080
`define CAR_OFF_FLUSH_STAT  12'h084

`define CAR_F_MTYPE_LO      0
`define CAR_F_TGT_LO        2
`define CAR_F_AGE_LO        4
`define CAR_F_AGEOPT        6
`define CAR_F_REVSKIP       7
`define CAR_F_SKIP_LO       8
`define CAR_F_FAULT_LO      11
`define CAR_F_QOS_LO        22

`define CAR_AGE_RESET       2'h3
`define CAR_MT_PAGE         2'h0
`define CAR_MT_UC           2'h1
`define CAR_MT_WT           2'h2
`define CAR_MT_WB           2'h3
`define CAR_TGT_PAGE        2'h0
`define CAR_TGT_LLC         2'h1
`define CAR_AGE_UNCORE      2'h0
`define CAR_AGE_ZERO        2'h1
`define CAR_AGE_KEEP        2'h2
`define CAR_AGE_THREE       2'h3

`define CAR_RC_UC           3'h0
`define CAR_RC_WC           3'h1
`define CAR_RC_WT           3'h4
`define CAR_RC_WP           3'h5
`define CAR_RC_WB           3'h6

`endif

/* File: core/car_pkg.sv */
/*
 * Types of the cache attribute resolver.
 * Assumes car_defines.svh is compiled alongside.
 */
package car_pkg;

    typedef enum logic [0:0] {
        FL_IDLE,
        FL_STALL_WAIT
    } car_flush_e;

    typedef logic [12:0] car_entry_t;

endpackage

/* File: core/car_resolver.sv */
/*
 * Cache attribute resolver: a table of 32 object control entries behind
 * a classic Wishbone slave, an access resolver with a one-cycle result,
 * and the frame-buffer flush sequencer that gates flip synchronisation.
 * Assumes all requesters and the last-level cache run on sys_clk.
 */
`timescale 1ns/1ps
`include "car_defines.svh"

// Summary of operation
// - Entries reset with age 11, other options zero, fixed type/target cycle.
// - Coherent memory type arrives apart from the index; index never altered.
// - On coherent accesses the separate memory type replaces the table type.
// - Range codes 0,1,4,6 map to 00,01,10,11; 2,3,7 are reserved.
// - Write-protected code 5 gives 11 on reads, 01 on writes.
// - Responses carry the entry's two-bit page fault mode.
// - Skip mask bits 10:8 need address bits 9,10,11 zero; clear means ignore.
// - Entry bit 7 picks normal (0) or reverse (1) skip sense.
// - Normal: LLC access matching stays in LLC, else goes to embedded cache.
// - Normal: embedded-only access matching stays, else becomes uncacheable.
// - Reverse: LLC access matching goes to embedded cache, else stays.
// - Reverse: embedded-only access matching becomes uncacheable, else stays.
// - Global QoS bits 23:22 apply to display-buffer accesses only.
// - After the stalling flush completes, command execution continues.
// - The LLC flush holds flip synchronisation from the cycle after it is taken until the LLC flush is done.
// - Type 00 page table, 01 uncacheable, 10 write-through, 11 write-back.
// - Target 00 page table, 01 LLC only, 10/11 LLC or embedded allowed.
// - Age 00 uncore, 01 age 0, 10 keep on hit, 11 age 3.
module car_resolver (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        reqValid,
    input  wire logic [4:0]  objectControlIndex,
    input  wire logic        reqWrite,
    input  wire logic        reqDisplay,
    input  wire logic        l3Coherent,
    input  wire logic [2:0]  coherentRangeCode,
    input  wire logic [11:9] reqAddr,
    input  wire logic [1:0]  pageMemType,
    input  wire logic        pageLlc,
    input  wire logic        pageEdram,
    input  wire logic [1:0]  uncoreAge,
    output logic             rspValid,
    output logic [1:0]       rspMemType,
    output logic             rspLlc,
    output logic             rspEdram,
    output logic [1:0]       rspAge,
    output logic             rspAgeKeep,
    output logic [1:0]       rspFaultMode,
    output logic             rspQosValid,
    output logic [1:0]       rspQos,
    output logic             rspRangeReserved,
    input  wire logic        flushValid,
    output logic             flushReady,
    input  wire logic        flushStall,
    input  wire logic        flushLlc,
    input  wire logic        pipeIdle,
    output logic             llcFlushReq,
    input  wire logic        llcFlushDone,
    input  wire logic        flipReq,
    output logic             flipSync
);

    ////////////////////////////////////////////////////////////////////////
    // Control entry table.

    function automatic car_pkg::car_entry_t entry_default(
        input logic [4:0] idx
    );
        logic [1:0]         mt;
        logic [1:0]         tg;
        car_pkg::car_entry_t e;
        mt = `CAR_MT_PAGE;
        tg = `CAR_TGT_PAGE;
        e  = '0;
        unique case (idx[3:0])
            4'h0: begin mt = 2'h0; tg = 2'h0; end
            4'h1: begin mt = 2'h0; tg = 2'h1; end
            4'h2: begin mt = 2'h0; tg = 2'h2; end
            4'h3: begin mt = 2'h1; tg = 2'h0; end
            4'h4, 4'ha: begin mt = 2'h2; tg = 2'h0; end
            4'h5, 4'hb: begin mt = 2'h2; tg = 2'h1; end
            4'h6, 4'hc: begin mt = 2'h2; tg = 2'h2; end
            4'h7, 4'hd: begin mt = 2'h3; tg = 2'h0; end
            4'h8, 4'he: begin mt = 2'h3; tg = 2'h1; end
            4'h9, 4'hf: begin mt = 2'h3; tg = 2'h2; end
        endcase
        e[`CAR_F_MTYPE_LO +: 2] = mt;
        e[`CAR_F_TGT_LO +: 2]   = tg;
        e[`CAR_F_AGE_LO +: 2]   = `CAR_AGE_RESET;
        return e;
    endfunction

    car_pkg::car_entry_t entry_r   [`CAR_ENTRY_COUNT];
    car_pkg::car_entry_t entry_nxt [`CAR_ENTRY_COUNT];
    logic [1:0]          qos_r;
    logic [1:0]          qos_nxt;
    logic                ack_r;
    logic                ack_nxt;
    logic [31:0]         rdat_r;
    logic [31:0]         rdat_nxt;
    logic                llcPending_r;
    logic                llcPending_nxt;
    logic                flipHeld_r;
    logic                flipHeld_nxt;
    car_pkg::car_flush_e flState_r;
    car_pkg::car_flush_e flState_nxt;

    logic        busHit;
    logic        entrySel;
    logic [4:0]  entryIdx;

    assign busHit   = wb_cyc_i && wb_stb_i && !ack_r;
    assign entrySel = (wb_adr_i[11:7] == 5'h00);
    assign entryIdx = wb_adr_i[6:2];

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave. Every access is acked one cycle after the strobe;
    // unmapped addresses read as zero and ignore writes.

    always_comb
    begin
        entry_nxt = entry_r;
        qos_nxt   = qos_r;
        ack_nxt   = busHit;
        rdat_nxt  = 32'h0000_0000;
        if (busHit && entrySel)
        begin
            rdat_nxt = {19'h0_0000, entry_r[entryIdx]};
            if (wb_we_i)
            begin
                if (wb_sel_i[0])
                    entry_nxt[entryIdx][7:0] = wb_dat_i[7:0];
                if (wb_sel_i[1])
                    entry_nxt[entryIdx][12:8] = wb_dat_i[12:8];
            end
        end
        else if (busHit && wb_adr_i == `CAR_OFF_ICR)
        begin
            rdat_nxt[`CAR_F_QOS_LO +: 2] = qos_r;
            if (wb_we_i && wb_sel_i[2])
                qos_nxt = wb_dat_i[`CAR_F_QOS_LO +: 2];
        end
        else if (busHit && wb_adr_i == `CAR_OFF_FLUSH_STAT)
        begin
            rdat_nxt[2:0] = {flipHeld_r, llcPending_r,
                             flState_r == car_pkg::FL_STALL_WAIT};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < `CAR_ENTRY_COUNT; i++)
                entry_r[i] <= entry_default(5'(i));
            qos_r  <= 2'h0;
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end
        else
        begin
            entry_r <= entry_nxt;
            qos_r   <= qos_nxt;
            ack_r   <= ack_nxt;
            rdat_r  <= rdat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    ////////////////////////////////////////////////////////////////////////
    // Access resolution, registered one cycle after reqValid.

    car_pkg::car_entry_t ent;
    logic [1:0]  mtSep;
    logic        rangeRsvd;
    logic [2:0]  skipMask;
    logic        skipOn;
    logic        skipMatch;
    logic [1:0]  mt;
    logic        llc;
    logic        edram;
    logic [1:0]  age;
    logic        ageKeep;
    logic        v_r;
    logic [1:0]  mt_r;
    logic        llc_r;
    logic        edram_r;
    logic [1:0]  age_r;
    logic        ageKeep_r;
    logic [1:0]  faultMode_r;
    logic        qosV_r;
    logic [1:0]  qosOut_r;
    logic        rsvd_r;

    // The coherent type travels on its own port; the index is used as is.
    assign ent = entry_r[objectControlIndex];

    always_comb
    begin
        mtSep     = `CAR_MT_PAGE;
        rangeRsvd = 1'b0;
        unique case (coherentRangeCode)
            `CAR_RC_UC: mtSep = 2'h0;
            `CAR_RC_WC: mtSep = 2'h1;
            `CAR_RC_WT: mtSep = 2'h2;
            `CAR_RC_WB: mtSep = 2'h3;
            `CAR_RC_WP: mtSep = reqWrite ? 2'h1 : 2'h3;
            default:    rangeRsvd = 1'b1;
        endcase
    end

    always_comb
    begin
        mt = ent[`CAR_F_MTYPE_LO +: 2];
        if (l3Coherent)
            mt = mtSep;
        if (mt == `CAR_MT_PAGE)
            mt = pageMemType;
        unique case (ent[`CAR_F_TGT_LO +: 2])
            2'h0:    begin llc = pageLlc; edram = pageEdram; end
            2'h1:    begin llc = 1'b1;    edram = 1'b0;      end
            default: begin llc = 1'b1;    edram = 1'b1;      end
        endcase
        skipMask  = ent[`CAR_F_SKIP_LO +: 3];
        skipOn    = (skipMask != 3'h0);
        skipMatch = ((reqAddr & skipMask) == 3'h0);
        if (skipOn && mt != `CAR_MT_UC)
        begin
            // Reverse sense simply inverts which outcome keeps caching.
            if (llc)
            begin
                if (skipMatch == ent[`CAR_F_REVSKIP])
                begin
                    llc   = 1'b0;
                    edram = 1'b1;
                end
            end
            else if (edram)
            begin
                if (skipMatch == ent[`CAR_F_REVSKIP])
                begin
                    mt    = `CAR_MT_UC;
                    edram = 1'b0;
                end
            end
        end
        ageKeep = 1'b0;
        unique case (ent[`CAR_F_AGE_LO +: 2])
            `CAR_AGE_UNCORE: age = uncoreAge;
            `CAR_AGE_ZERO:   age = 2'h0;
            `CAR_AGE_KEEP:   begin age = 2'h0; ageKeep = 1'b1; end
            `CAR_AGE_THREE:  age = 2'h3;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            v_r       <= 1'b0;
            mt_r      <= 2'h0;
            llc_r     <= 1'b0;
            edram_r   <= 1'b0;
            age_r     <= 2'h0;
            ageKeep_r <= 1'b0;
            faultMode_r <= 2'h0;
            qosV_r    <= 1'b0;
            qosOut_r  <= 2'h0;
            rsvd_r    <= 1'b0;
        end
        else
        begin
            v_r <= reqValid;
            if (reqValid)
            begin
                mt_r      <= mt;
                llc_r     <= llc;
                edram_r   <= edram;
                age_r     <= age;
                ageKeep_r <= ageKeep;
                faultMode_r <= ent[`CAR_F_FAULT_LO +: 2];
                qosV_r    <= reqDisplay;
                qosOut_r  <= reqDisplay ? qos_r : 2'h0;
                rsvd_r    <= l3Coherent && rangeRsvd;
            end
        end
    end

    assign rspValid         = v_r;
    assign rspMemType       = mt_r;
    assign rspLlc           = llc_r;
    assign rspEdram         = edram_r;
    assign rspAge           = age_r;
    assign rspAgeKeep       = ageKeep_r;
    assign rspFaultMode     = faultMode_r;
    assign rspQosValid      = qosV_r;
    assign rspQos           = qosOut_r;
    assign rspRangeReserved = rsvd_r;

    ////////////////////////////////////////////////////////////////////////
    // Flush sequencer. A stalling flush waits for pipeline idle and then
    // frees the ring; an LLC flush is accepted at once and only the flip
    // is held, so the next frame overlaps the LLC write-back.

    logic flushTake;

    always_comb
    begin
        flState_nxt    = flState_r;
        llcPending_nxt = llcPending_r;
        flipHeld_nxt   = flipHeld_r;
        flushReady     = 1'b0;
        flipSync       = 1'b0;
        unique case (flState_r)
            car_pkg::FL_IDLE:
            begin
                flushReady = !flushStall || pipeIdle;
                if (flushValid && flushStall && !pipeIdle)
                    flState_nxt = car_pkg::FL_STALL_WAIT;
            end
            car_pkg::FL_STALL_WAIT:
            begin
                flushReady = pipeIdle;
                if (pipeIdle)
                    flState_nxt = car_pkg::FL_IDLE;
            end
        endcase
        flushTake = flushValid && flushReady;
        if (llcFlushDone)
            llcPending_nxt = 1'b0;
        if (flushTake && flushLlc)
            llcPending_nxt = 1'b1;
        if (flipReq)
            flipHeld_nxt = 1'b1;
        if ((flipHeld_r || flipReq) && !llcPending_r)
        begin
            flipSync     = 1'b1;
            flipHeld_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            flState_r    <= car_pkg::FL_IDLE;
            llcPending_r <= 1'b0;
            flipHeld_r   <= 1'b0;
        end
        else
        begin
            flState_r    <= flState_nxt;
            llcPending_r <= llcPending_nxt;
            flipHeld_r   <= flipHeld_nxt;
        end
    end

    assign llcFlushReq = llcPending_r;

endmodule

/* File: dv/car_resolver_chk.sv */
/*
 * Port checker of the cache attribute resolver.
 * Assumes a bind to car_resolver, one clock sys_clk and srst.
 */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module car_resolver_chk (
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       reqValid,
    input wire logic       reqWrite,
    input wire logic       reqDisplay,
    input wire logic       l3Coherent,
    input wire logic [2:0] coherentRangeCode,
    input wire logic       rspValid,
    input wire logic [1:0] rspMemType,
    input wire logic       rspQosValid,
    input wire logic       rspRangeReserved,
    input wire logic       flushValid,
    input wire logic       flushReady,
    input wire logic       flushStall,
    input wire logic       flushLlc,
    input wire logic       pipeIdle,
    input wire logic       llcFlushReq,
    input wire logic       llcFlushDone,
    input wire logic       flipReq,
    input wire logic       flipSync
);
    logic resvIn;
    logic wpIn;
    logic llcTake;

    assign resvIn = l3Coherent
                    && coherentRangeCode inside {3'h2, 3'h3, 3'h7};
    assign wpIn = l3Coherent && coherentRangeCode == 3'h5;
    assign llcTake = flushValid && flushReady && flushLlc;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
////////////////////////////////////////////////////////////////////////
    ack_latency_a:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack missing one cycle after request");
    rsp_timing_a:
        assert property (rspValid == $past(reqValid))
        else $error("lookup result not one cycle after request");
    qos_display_a:
        assert property (rspValid |-> rspQosValid == $past(reqDisplay))
        else $error("qos applied to a non-display access");
    range_resv_a:
        assert property (rspValid |-> rspRangeReserved == $past(resvIn))
        else $error("reserved range flag wrong");
    // Reads of protected memory act as write-back, writes as combining.
    wp_type_a:
        assert property (rspValid && $past(wpIn)
                         |-> rspMemType == {!$past(reqWrite), 1'b1})
        else $error("protected range type wrong");
    llc_start_a:
        assert property (llcTake |=> llcFlushReq)
        else $error("cache flush request not raised");
    flip_hold_a:
        assert property (llcFlushReq |-> !flipSync)
        else $error("flip granted during cache flush");
    flip_free_a:
        assert property (flipReq && !llcFlushReq |-> flipSync)
        else $error("flip withheld with nothing pending");
    stall_gate_a:
        assert property (flushStall && !pipeIdle |-> !flushReady)
        else $error("stalling flush taken while pipeline busy");
    llc_clear_a:
        assert property (llcFlushReq && llcFlushDone && !llcTake
                         |=> !llcFlushReq ##1 !llcFlushReq)
        else $error("cache flush request not cleared by done");
endmodule

/* File: dv/car_flush_partner.sv */
/*
 * Far-side model: pipeline drain and last-level cache flush engine.
 * Assumes the same clock and reset as the resolver.
 */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module car_flush_partner (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic slow,
    input  wire logic kick,
    input  wire logic llcFlushReq,
    output logic      llcFlushDone,
    output logic      pipeIdle
);
    logic [3:0] drain_r;
    logic [3:0] drain_nxt;
    logic [3:0] wait_r;
    logic [3:0] wait_nxt;
    logic       done_nxt;

    assign pipeIdle = drain_r == 4'h0;

    // A slow partner keeps the pipeline busy and the flush long.
    always_comb
    begin
        drain_nxt = (drain_r != 4'h0) ? drain_r - 4'h1 : 4'h0;
        if (kick)
            drain_nxt = slow ? 4'h9 : 4'h2;
        done_nxt = 1'b0;
        wait_nxt = 4'h0;
        if (llcFlushReq && !llcFlushDone)
        begin
            wait_nxt = wait_r + 4'h1;
            done_nxt = wait_r == (slow ? 4'hc : 4'h0);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        drain_r <= srst ? 4'h0 : drain_nxt;
        wait_r <= srst ? 4'h0 : wait_nxt;
        llcFlushDone <= srst ? 1'b0 : done_nxt;
    end
endmodule

/* File: dv/tb_car_resolver.sv */
/*
 * Self-checking bench of the cache attribute resolver.
 * Assumes the checker and the flush partner are compiled before it.
 */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module tb_car_resolver;
    logic        sys_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        reqValid, reqWrite, reqDisplay, l3Coherent, pageLlc;
    logic        pageEdram, rspValid, rspLlc, rspEdram, rspAgeKeep;
    logic        rspQosValid, rspRangeReserved, flushValid, flushReady;
    logic        flushStall, flushLlc, pipeIdle, llcFlushReq, llcFlushDone;
    logic        flipReq, flipSync, slow, kick;
    logic [1:0]  pageMemType, uncoreAge, rspMemType, rspAge, rspFaultMode;
    logic [1:0]  rspQos, qos;
    logic [2:0]  coherentRangeCode, reqAddr;
    logic [3:0]  wb_sel_i;
    logic [4:0]  objectControlIndex;
    logic [11:0] wb_adr_i;
    logic [12:0] tbl [32];
    logic [31:0] wb_dat_i, wb_dat_o, rng, rdQ [$];
    logic [12:0] lkQ [$];
    int          num_errors, checks_done, cycN;

    car_resolver i_car_resolver (.*);
    car_flush_partner i_car_flush_partner (.*);

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results();
        if (num_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////
    task automatic wb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
            @(posedge sys_clk);
        while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic lookup();
        logic [31:0] r;
        logic [12:0] e;
        logic [2:0]  code;
        logic [1:0]  mt, ag;
        logic        coh, l, m, k;
        rng = xs(rng);
        r = rng;
        e = tbl[r[4:0]];
        code = r[10:8];
        coh = r[7] && e[10:8] == 3'h0;
        @(posedge sys_clk);
        reqValid <= 1'b1;
        objectControlIndex <= r[4:0];
        reqWrite <= r[5];
        reqDisplay <= r[6];
        l3Coherent <= coh;
        coherentRangeCode <= code;
        reqAddr <= r[13:11];
        {pageMemType, pageEdram, pageLlc} <= r[15:14 - 2];
        uncoreAge <= r[19:18];
        mt = e[1:0];
        if (coh)
            mt = code == 3'h5 ? {!r[5], 1'b1} : code == 3'h4 ? 2'h2
                 : code == 3'h6 ? 2'h3 : {1'b0, code == 3'h1};
        mt = mt == 2'h0 ? r[15:14] : mt;
        {l, m} = e[3:2] == 2'h0 ? {r[12], r[13]} : {1'b1, e[3]};
        k = e[5:4] == 2'h2;
        ag = e[5:4] == 2'h0 ? r[19:18] : {2{e[5:4] == 2'h3}};
        // A miss in normal sense, or a match in reverse sense, demotes.
        if (e[10:8] != 3'h0 && mt != 2'h1
            && (((e[10:8] & r[13:11]) == 3'h0) == e[7]))
            {mt, l, m} = l ? {mt, 2'b01} : m ? 4'b0100 : {mt, l, m};
        lkQ.push_back({coh && code inside {3'h2, 3'h3, 3'h7}, mt, l, m, ag,
                       k, e[12:11], r[6], r[6] ? qos : 2'h0});
    endtask
////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk)
    begin
        cycN++;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            check("rdata", wb_dat_o, rdQ.pop_front());
        if (rspValid === 1'b1)
            check("lookup", 32'({rspRangeReserved, rspMemType, rspLlc,
                  rspEdram, rspAge, rspAgeKeep, rspFaultMode, rspQosValid,
                  rspQos & {2{rspQosValid}}}), 32'(lkQ.pop_front()));
        if (cycN == 8000)
        begin
            num_errors++;
            results();
        end
    end

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        srst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, reqValid} = '0;
        {objectControlIndex, reqWrite, reqDisplay, l3Coherent} = '0;
        {coherentRangeCode, reqAddr, pageMemType, pageLlc} = '0;
        {pageEdram, uncoreAge, flushValid, flushStall, flushLlc} = '0;
        {flipReq, slow, kick} = '0;
        wb_sel_i = 4'hf;
        rng = 32'hbe9c7198;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        qos = rng[23:22];
        wb(1'b1, 12'h080, {8'h00, qos, 22'h000000});
        for (int i = 0; i < 32; i++)
        begin
            rdQ.push_back(32'h30 | 64'hb73a62b73a621840 >> (4 * (i % 16))
                          & 32'hf | 32'h30);
            wb(1'b0, {5'h00, i[4:0], 2'h0}, 32'h0);
            rng = xs(rng);
            tbl[i] = rng[12:0];
            wb(1'b1, {5'h00, i[4:0], 2'h0}, {19'h0, tbl[i]});
            rdQ.push_back({19'h0, tbl[i]});
            wb(1'b0, {5'h00, i[4:0], 2'h0}, 32'h0);
        end
        wb(1'b1, 12'h0fc, 32'hffffffff);
        rdQ.push_back(32'h0);
        wb(1'b0, 12'h0fc, 32'h0);
        repeat (300) lookup();
        @(posedge sys_clk);
        reqValid <= 1'b0;
        for (int s = 0; s < 2; s++)
        begin
            @(posedge sys_clk);
            slow <= s[0];
            kick <= 1'b1;
            @(posedge sys_clk);
            kick <= 1'b0;
            {flushValid, flushStall} <= 2'b11;
            do
                @(posedge sys_clk);
            while (flushReady !== 1'b1);
            {flushStall, flushLlc} <= 2'b01;
            @(posedge sys_clk);
            check("ready", 32'(flushReady), 32'h1);
            {flushValid, flushLlc, flipReq} <= 3'b001;
            @(posedge sys_clk);
            flipReq <= 1'b0;
            do
                @(posedge sys_clk);
            while (flipSync !== 1'b1);
            check("flip", 32'(llcFlushReq), 32'h0);
        end
        repeat (4) @(posedge sys_clk);
        results();
    end
endmodule

bind car_resolver car_resolver_chk i_car_resolver_chk (.*);
